// ### core/sto_pkg.sv
`default_nettype none
package sto_pkg;
	// Clock of both ends
	localparam int CLK_PERIOD_NS = 40;

	// Longest test-pulse off interval that the inputs must ride through
	localparam int TEST_PULSE_MAX_MS = 1;
	localparam int TEST_PULSE_MAX_CYC = TEST_PULSE_MAX_MS * 1000000 / CLK_PERIOD_NS;

	// Off interval of the controller's own test pulse
	localparam int CTL_PULSE_OFF_US = 500;
	localparam int CTL_PULSE_OFF_CYC = CTL_PULSE_OFF_US * 1000 / CLK_PERIOD_NS;

	// Counter width and the counts at that width
	localparam int CNT_W = 15;
	localparam logic [CNT_W-1:0] TEST_PULSE_MAX_CNT = CNT_W'(TEST_PULSE_MAX_CYC);
	localparam logic [CNT_W-1:0] CTL_PULSE_OFF_CNT = CNT_W'(CTL_PULSE_OFF_CYC);

	// Rated number of torque-off operations
	localparam int LIFE_W = 20;
	localparam logic [LIFE_W-1:0] STO_LIFE_COUNT = 20'h0f4240;

	// Register bus
	localparam int AXI_ADDR_W = 5;
	localparam int AXI_DATA_W = 32;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Register offsets
	localparam logic [AXI_ADDR_W-1:0] REG_CTRL = 5'h00;
	localparam logic [AXI_ADDR_W-1:0] REG_CMD = 5'h04;
	localparam logic [AXI_ADDR_W-1:0] REG_STATUS = 5'h08;
	localparam logic [AXI_ADDR_W-1:0] REG_IRQ_STAT = 5'h0c;
	localparam logic [AXI_ADDR_W-1:0] REG_IRQ_MASK = 5'h10;

	// Control fields
	localparam int CTRL_W = 3;
	localparam int CTRL_TOFF_BIT = 0;
	localparam int CTRL_UNIT_RESET_A_BIT = 1;
	localparam int CTRL_UNIT_RESET_B_BIT = 2;
	localparam logic [CTRL_W-1:0] CTRL_RST = 3'h1;
	localparam int CMD_PULSE_BIT = 0;

	// Interrupt fields
	localparam int IRQ_W = 3;
	localparam int IRQ_SERIES_BIT = 0;
	localparam int IRQ_RELEASE_BIT = 1;
	localparam int IRQ_MISMATCH_BIT = 2;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

	// Controller sequence
	typedef enum logic [1:0] {
		CT_LOCKED,
		CT_RUN,
		CT_STOPPING,
		CT_PULSE
	} sto_ctl_state_e;
endpackage
`default_nettype wire

// ### core/sto_link_if.sv
`timescale 1ns/1ps
`default_nettype none
// Safety wiring between the drive and its safety controller
interface sto_link_if;
	logic safetyInputOne;       // High: input one closed to its common
	logic safetyInputTwo;       // High: input two closed to its common
	logic forcedStopTwoInput;   // High: forced stop two released
	logic shutoffMonitorOne;    // High: monitor one closed
	logic shutoffMonitorTwo;    // High: monitor two closed
	logic shutoffMonitorSeries; // High: series path conducts

	modport dev (
		input  safetyInputOne,
		input  safetyInputTwo,
		input  forcedStopTwoInput,
		output shutoffMonitorOne,
		output shutoffMonitorTwo,
		output shutoffMonitorSeries
	);

	modport ctl (
		output safetyInputOne,
		output safetyInputTwo,
		output forcedStopTwoInput,
		input  shutoffMonitorOne,
		input  shutoffMonitorTwo,
		input  shutoffMonitorSeries
	);
endinterface
`default_nettype wire

// ### core/sto_drive_end.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RULE1: Open input one forces base shut-off
// RULE2: Open input two forces base shut-off
// RULE3: Drive only with both inputs closed
// RULE4: Monitor one closed while channel one off
// RULE5: Monitor two closed while channel two off
// RULE6: Series path conducts only both open
// RULE7: Off pulses up to 1 ms ignored
// RULE8: Controller opens inputs only after stop
// RULE9: Controller opens both inputs together
// RULE10: Torque-off while running: brake and alarm
// RULE11: Maintenance alarms and warnings are reported
// RULE12: Release needs both unit resets pulsed
// RULE13: No forced-stop deceleration in torque mode
// RULE14: Restart only on fresh servo-on command
module sto_drive_end #(
	parameter logic [sto_pkg::CNT_W-1:0] PULSE_CYC = sto_pkg::TEST_PULSE_MAX_CNT
) (
	input  wire logic                        mclk,
	input  wire logic                        rst,
	sto_link_if.dev                          link,
	input  wire logic                        servoOnCmd,
	input  wire logic                        motorMoving,
	input  wire logic                        torqueMode,
	input  wire logic                        alarmClear,
	output logic                             baseDriveEnable,
	output logic                             forcedDecel,
	output logic                             dynamicBrake,
	output logic                             stoActive,
	output logic                             torqueOffTimingAlarm,
	output logic                             channelMismatchWarn,
	output logic                             lifeWarning,
	output logic [sto_pkg::LIFE_W-1:0]       stoCycleCount
);
	import sto_pkg::*;

	// Whole state of the drive end
	typedef struct packed {
		logic [2:0]            syncA;
		logic [2:0]            syncB;
		logic [2:0]            syncC;
		logic [1:0][CNT_W-1:0] openCnt;
		logic [1:0]            chOpen;
		logic                  em2Open;
		logic                  servoOnPrev;
		logic                  baseDrive;
		logic                  decel;
		logic                  dynBrake;
		logic                  alarm;
		logic                  warn;
		logic                  active;
		logic [LIFE_W-1:0]     lifeCnt;
		logic                  lifeWarn;
		logic                  monOne;
		logic                  monTwo;
		logic                  monSeries;
	} sto_dev_s;

	// Channels start in shut-off with their monitors closed
	localparam sto_dev_s DEV_RST = '{
		chOpen:    2'h3,
		em2Open:   1'b1,
		active:    1'b1,
		monOne:    1'b1,
		monTwo:    1'b1,
		monSeries: 1'b1,
		default:   '0
	};

	sto_dev_s r_q;
	sto_dev_s r_d;
	logic     newOn;
	logic     anyOpen;
	logic     runningAtOpen;

	// Next state of the whole drive end
	always_comb begin
		r_d = r_q;
		newOn = 1'b0;
		anyOpen = 1'b0;
		runningAtOpen = 1'b0;

		// Three-stage capture of the safety and forced-stop pins
		r_d.syncA = {link.forcedStopTwoInput, link.safetyInputTwo, link.safetyInputOne};
		r_d.syncB = r_q.syncA;
		r_d.syncC = r_q.syncB;

		// Closing counts at once, opening only after the pulse window
		for (int i = 0; i < 2; i++) begin
			if (r_q.syncB[i] == r_q.syncC[i]) begin
				if (r_q.syncC[i]) begin
					r_d.openCnt[i] = '0;
					r_d.chOpen[i] = 1'b0;
				end else if (r_q.openCnt[i] >= PULSE_CYC) begin
					r_d.chOpen[i] = 1'b1; // see RULE1, see RULE2
				end else begin
					r_d.openCnt[i] = r_q.openCnt[i] + 1'b1; // see RULE7
				end
			end
		end

		// Forced stop two follows its pin once the last two stages agree
		if (r_q.syncB[2] == r_q.syncC[2]) begin
			r_d.em2Open = ~r_q.syncC[2];
		end

		// Servo-on edge detection; a held level never restarts the motor
		newOn = servoOnCmd & ~r_q.servoOnPrev;
		r_d.servoOnPrev = servoOnCmd;
		anyOpen = |r_q.chOpen;
		runningAtOpen = r_q.baseDrive | motorMoving;

		// Software clear first so that a new event in the same cycle wins
		if (alarmClear) begin
			r_d.alarm = 1'b0;
		end

		// Drive permission
		if (anyOpen) begin
			r_d.baseDrive = 1'b0; // see RULE3
			r_d.decel = 1'b0;
			if (runningAtOpen) begin
				r_d.alarm = 1'b1; // see RULE10
			end
		end else if (r_q.alarm) begin
			r_d.baseDrive = 1'b0;
			r_d.decel = 1'b0;
		end else if (r_q.em2Open) begin
			if (torqueMode || !motorMoving) begin
				r_d.baseDrive = 1'b0; // see RULE13
				r_d.decel = 1'b0;
			end else begin
				r_d.decel = r_q.baseDrive;
			end
		end else begin
			r_d.decel = 1'b0;
			if (!servoOnCmd) begin
				r_d.baseDrive = 1'b0;
			end else if (newOn) begin
				r_d.baseDrive = 1'b1; // see RULE14
			end
		end

		// Dynamic brake while the alarm stands or a cut motor still turns
		r_d.dynBrake = r_d.alarm
			| (~r_d.baseDrive & motorMoving & (anyOpen | r_q.em2Open)); // see RULE10

		// Maintenance: channel disagreement and wear count
		r_d.warn = r_q.chOpen[0] ^ r_q.chOpen[1]; // see RULE11
		r_d.active = |r_d.chOpen;
		if (r_d.active && !r_q.active && (r_q.lifeCnt != STO_LIFE_COUNT)) begin
			r_d.lifeCnt = r_q.lifeCnt + 1'b1;
		end
		r_d.lifeWarn = (r_q.lifeCnt == STO_LIFE_COUNT); // see RULE11

		// Monitor contacts mirror the qualified channel states
		r_d.monOne = r_d.chOpen[0]; // see RULE4
		r_d.monTwo = r_d.chOpen[1]; // see RULE5
		r_d.monSeries = &r_d.chOpen; // see RULE6
	end

	// State register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			r_q <= DEV_RST;
		end else begin
			r_q <= r_d;
		end
	end

	// Outputs straight from the state register
	assign link.shutoffMonitorOne = r_q.monOne;
	assign link.shutoffMonitorTwo = r_q.monTwo;
	assign link.shutoffMonitorSeries = r_q.monSeries;
	assign baseDriveEnable = r_q.baseDrive;
	assign forcedDecel = r_q.decel;
	assign dynamicBrake = r_q.dynBrake;
	assign stoActive = r_q.active;
	assign torqueOffTimingAlarm = r_q.alarm;
	assign channelMismatchWarn = r_q.warn;
	assign lifeWarning = r_q.lifeWarn;
	assign stoCycleCount = r_q.lifeCnt;
endmodule
`default_nettype wire

// ### core/sto_safety_ctrl.sv
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module sto_safety_ctrl #(
	parameter logic [sto_pkg::CNT_W-1:0] PULSE_OFF_CYC = sto_pkg::CTL_PULSE_OFF_CNT
) (
	input  wire logic                          mclk,
	input  wire logic                          rst,
	sto_link_if.ctl                            link,
	input  wire logic                          motorStopped,
	input  wire logic [sto_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [sto_pkg::AXI_DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [sto_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic [sto_pkg::AXI_DATA_W-1:0]     s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	output logic                               irq
);
	import sto_pkg::*;

	typedef struct packed {
		sto_ctl_state_e         state;
		logic                   resetSeen;
		logic [CNT_W-1:0]       pulseCnt;
		logic                   inClosed;
		logic                   em2Closed;
		logic [2:0]             mS1;
		logic [2:0]             mS2;
		logic [2:0]             mS3;
		logic [2:0]             mon;
		logic [CTRL_W-1:0]      ctrl;
		logic [IRQ_W-1:0]       irqStat;
		logic [IRQ_W-1:0]       irqMask;
		logic                   irq;
		logic                   awHave;
		logic                   wHave;
		logic [AXI_ADDR_W-1:0]  awAddr;
		logic [7:0]             wByte;
		logic                   wLane0;
		logic                   awready;
		logic                   wready;
		logic                   bvalid;
		logic [1:0]             bresp;
		logic                   arready;
		logic                   rvalid;
		logic [AXI_DATA_W-1:0]  rdata;
		logic [1:0]             rresp;
	} sto_ctl_s;

	// Monitor copies start closed, as the drive end shows them in reset,
	// so that leaving reset raises no false series event
	localparam sto_ctl_s CTL_RST = '{
		state:     CT_LOCKED,
		em2Closed: 1'b1,
		mS1:       3'h7,
		mS2:       3'h7,
		mS3:       3'h7,
		mon:       3'h7,
		ctrl:      CTRL_RST,
		irqMask:   IRQ_MASK_RST,
		awready:   1'b1,
		wready:    1'b1,
		arready:   1'b1,
		default:   '0
	};

	// Address decode shared by the read and write paths
	function automatic logic mapped(input logic [AXI_ADDR_W-1:0] a);
		mapped = (a == REG_CTRL) || (a == REG_CMD) || (a == REG_STATUS)
			|| (a == REG_IRQ_STAT) || (a == REG_IRQ_MASK);
	endfunction

	sto_ctl_s         r_q;
	sto_ctl_s         r_d;
	logic             wrDo;
	logic             pulseCmd;
	logic             relEv;
	logic [IRQ_W-1:0] irqSet;
	logic [IRQ_W-1:0] irqClr;

	always_comb begin
		r_d = r_q;
		wrDo = 1'b0;
		pulseCmd = 1'b0;
		relEv = 1'b0;
		irqSet = '0;
		irqClr = '0;

		// Monitor pins pass three stages; a bit moves once stages two and three agree
		r_d.mS1 = {link.shutoffMonitorSeries, link.shutoffMonitorTwo, link.shutoffMonitorOne};
		r_d.mS2 = r_q.mS1;
		r_d.mS3 = r_q.mS2;
		for (int i = 0; i < 3; i++) begin
			if (r_q.mS2[i] == r_q.mS3[i]) begin
				r_d.mon[i] = r_q.mS3[i];
			end
		end

		// Write channel: address and data taken in either order
		if (s_axi_awvalid && r_q.awready) begin
			r_d.awHave = 1'b1;
			r_d.awAddr = s_axi_awaddr;
			r_d.awready = 1'b0;
		end
		if (s_axi_wvalid && r_q.wready) begin
			r_d.wHave = 1'b1;
			r_d.wByte = s_axi_wdata[7:0];
			r_d.wLane0 = s_axi_wstrb[0];
			r_d.wready = 1'b0;
		end
		if (r_q.awHave && r_q.wHave && !r_q.bvalid) begin
			wrDo = r_q.wLane0;
			r_d.bvalid = 1'b1;
			r_d.bresp = mapped(r_q.awAddr) ? RESP_OKAY : RESP_SLVERR;
			r_d.awHave = 1'b0;
			r_d.wHave = 1'b0;
		end
		if (r_q.bvalid && s_axi_bready) begin
			r_d.bvalid = 1'b0;
			r_d.awready = 1'b1;
			r_d.wready = 1'b1;
		end
		if (wrDo) begin
			unique case (r_q.awAddr)
				REG_CTRL:     r_d.ctrl = r_q.wByte[CTRL_W-1:0];
				REG_CMD:      pulseCmd = r_q.wByte[CMD_PULSE_BIT];
				REG_IRQ_STAT: irqClr = r_q.wByte[IRQ_W-1:0];
				REG_IRQ_MASK: r_d.irqMask = r_q.wByte[IRQ_W-1:0];
				default:      r_d.ctrl = r_q.ctrl;
			endcase
		end

		// Read channel: data one cycle after the address is taken
		if (s_axi_arvalid && r_q.arready) begin
			r_d.rvalid = 1'b1;
			r_d.arready = 1'b0;
			r_d.rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			unique case (s_axi_araddr)
				REG_CTRL:     r_d.rdata = AXI_DATA_W'(r_q.ctrl);
				REG_STATUS:   r_d.rdata = AXI_DATA_W'({r_q.state == CT_STOPPING,
					r_q.inClosed, r_q.mon});
				REG_IRQ_STAT: r_d.rdata = AXI_DATA_W'(r_q.irqStat);
				REG_IRQ_MASK: r_d.rdata = AXI_DATA_W'(r_q.irqMask);
				default:      r_d.rdata = '0;
			endcase
		end
		if (r_q.rvalid && s_axi_rready) begin
			r_d.rvalid = 1'b0;
			r_d.arready = 1'b1;
		end

		// Torque-off sequence; one flop drives both safety inputs
		unique case (r_q.state)
			CT_LOCKED: begin
				if (r_q.ctrl[CTRL_UNIT_RESET_A_BIT] && r_q.ctrl[CTRL_UNIT_RESET_B_BIT]) begin
					r_d.resetSeen = 1'b1;
				end else if (r_q.resetSeen && !r_q.ctrl[CTRL_UNIT_RESET_A_BIT]
					&& !r_q.ctrl[CTRL_UNIT_RESET_B_BIT] && !r_q.ctrl[CTRL_TOFF_BIT]) begin
					r_d.state = CT_RUN; // see RULE12
					r_d.inClosed = 1'b1;
					r_d.resetSeen = 1'b0;
					relEv = 1'b1;
				end
			end
			CT_RUN: begin
				if (r_q.ctrl[CTRL_TOFF_BIT]) begin
					r_d.state = CT_STOPPING;
					r_d.em2Closed = 1'b0; // see RULE8
				end else if (pulseCmd) begin
					r_d.state = CT_PULSE;
					r_d.inClosed = 1'b0;
					r_d.pulseCnt = '0;
				end
			end
			CT_STOPPING: begin
				if (motorStopped) begin
					r_d.state = CT_LOCKED; // see RULE8
					r_d.inClosed = 1'b0; // see RULE9
					r_d.em2Closed = 1'b1;
					r_d.resetSeen = 1'b0;
				end
			end
			CT_PULSE: begin
				if (r_q.pulseCnt >= PULSE_OFF_CYC - 1'b1) begin
					r_d.state = CT_RUN; // see RULE7
					r_d.inClosed = 1'b1;
				end else begin
					r_d.pulseCnt = r_q.pulseCnt + 1'b1;
				end
			end
		endcase

		// Sticky events, cleared by writing one; a new event wins
		irqSet[IRQ_SERIES_BIT] = r_d.mon[2] & ~r_q.mon[2];
		irqSet[IRQ_RELEASE_BIT] = relEv;
		irqSet[IRQ_MISMATCH_BIT] = (r_d.mon[0] ^ r_d.mon[1]) & ~(r_q.mon[0] ^ r_q.mon[1]);
		r_d.irqStat = (r_q.irqStat & ~irqClr) | irqSet;
		r_d.irq = |(r_d.irqStat & r_d.irqMask);
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			r_q <= CTL_RST;
		end else begin
			r_q <= r_d;
		end
	end

	assign link.safetyInputOne = r_q.inClosed;
	assign link.safetyInputTwo = r_q.inClosed;
	assign link.forcedStopTwoInput = r_q.em2Closed;
	assign s_axi_awready = r_q.awready;
	assign s_axi_wready = r_q.wready;
	assign s_axi_bvalid = r_q.bvalid;
	assign s_axi_bresp = r_q.bresp;
	assign s_axi_arready = r_q.arready;
	assign s_axi_rvalid = r_q.rvalid;
	assign s_axi_rdata = r_q.rdata;
	assign s_axi_rresp = r_q.rresp;
	assign irq = r_q.irq;
endmodule
`default_nettype wire

// ### testbench/sto_link_chk.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the safety wiring between controller and drive end
module sto_link_chk #(
	parameter int PULSE_CYC = 20
) (
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic safetyInputOne,
	input  wire logic safetyInputTwo,
	input  wire logic forcedStopTwoInput,
	input  wire logic shutoffMonitorOne,
	input  wire logic shutoffMonitorTwo,
	input  wire logic shutoffMonitorSeries
);
	int openCnt;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	// Cycles that input one has stayed open, saturating
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			openCnt <= 0;
		end else if (safetyInputOne) begin
			openCnt <= 0;
		end else if (openCnt < 255) begin
			openCnt <= openCnt + 1;
		end
	end

	a_series_both: assert property (shutoffMonitorSeries == (shutoffMonitorOne && shutoffMonitorTwo))
		else $error("series path disagrees with monitors");
	a_mon_agree: assert property (shutoffMonitorOne == shutoffMonitorTwo)
		else $error("monitors disagree with paired inputs");
	a_inputs_pair: assert property (safetyInputOne == safetyInputTwo)
		else $error("safety inputs not switched together");
	a_close_release: assert property ($rose(safetyInputOne) |-> ##[1:8] !shutoffMonitorOne)
		else $error("channel not released after close");
	a_pulse_ride: assert property ($fell(safetyInputOne) && !shutoffMonitorOne |-> !shutoffMonitorOne [*8])
		else $error("short open pulse shut the channel");
	a_open_shut: assert property (openCnt == PULSE_CYC + 10 |-> shutoffMonitorOne && shutoffMonitorSeries)
		else $error("long open did not shut off");
	a_stop_first: assert property ($rose(forcedStopTwoInput) |-> !safetyInputOne)
		else $error("forced stop released before inputs opened");
	a_decel_closed: assert property ($fell(forcedStopTwoInput) |-> safetyInputOne && safetyInputTwo)
		else $error("deceleration started with inputs open");

	// Main scenarios
	c_series: cover property ($rose(shutoffMonitorSeries));
	c_pulse: cover property ($fell(safetyInputOne) && !shutoffMonitorOne);
	c_decel: cover property ($fell(forcedStopTwoInput));
	c_release: cover property ($rose(safetyInputOne));
endmodule
`default_nettype wire

// ### testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import sto_pkg::*;

	typedef struct {
		logic [1:0]  kind;
		logic [35:0] val;
		logic [35:0] mask;
	} sto_note_s;

	localparam logic [35:0] ALL = '1;
	logic        mclk, rst, servoOnCmd, motorMoving, torqueMode, alarmClear, motorStopped;
	logic        inB1, inB2, snapReq, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, irq, base, decel, brake;
	logic        stoAct, alarm, mism, life, stoActB, mismB;
	logic [4:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rnd;
	logic [1:0]  bresp, rresp;
	logic [35:0] pins;
	logic [19:0] cnt;
	logic [3:0]  strb;
	logic [1:0]  cases [3] = '{2'b01, 2'b10, 2'b00};
	sto_note_s   notes [$];
	int          errors = 0;
	int          checked = 0;
	int          cycles = 0;

	sto_link_if lnk();
	sto_link_if lnk2();

	// Second link driven by the bench, which may break the pairing on purpose
	assign lnk2.safetyInputOne = inB1;
	assign lnk2.safetyInputTwo = inB2;
	assign lnk2.forcedStopTwoInput = 1'b1;
	assign pins = {cnt, irq, base, decel, brake, stoAct, alarm, mism, life,
		lnk.shutoffMonitorOne, lnk.shutoffMonitorTwo, lnk.shutoffMonitorSeries, stoActB, mismB,
		lnk2.shutoffMonitorOne, lnk2.shutoffMonitorTwo, lnk2.shutoffMonitorSeries};

	sto_safety_ctrl #(.PULSE_OFF_CYC(15'd8)) i_sto_safety_ctrl (.mclk(mclk), .rst(rst),
		.link(lnk), .motorStopped(motorStopped), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.irq(irq));
	sto_drive_end #(.PULSE_CYC(15'd20)) i_sto_drive_end (.mclk(mclk), .rst(rst), .link(lnk),
		.servoOnCmd(servoOnCmd), .motorMoving(motorMoving), .torqueMode(torqueMode),
		.alarmClear(alarmClear), .baseDriveEnable(base), .forcedDecel(decel),
		.dynamicBrake(brake), .stoActive(stoAct), .torqueOffTimingAlarm(alarm),
		.channelMismatchWarn(mism), .lifeWarning(life), .stoCycleCount(cnt));
	sto_drive_end #(.PULSE_CYC(15'd20)) i_sto_drive_end_2 (.mclk(mclk), .rst(rst), .link(lnk2),
		.servoOnCmd(servoOnCmd), .motorMoving(motorMoving), .torqueMode(torqueMode),
		.alarmClear(alarmClear), .baseDriveEnable(), .forcedDecel(), .dynamicBrake(),
		.stoActive(stoActB), .torqueOffTimingAlarm(), .channelMismatchWarn(mismB),
		.lifeWarning(), .stoCycleCount());
	sto_link_chk #(.PULSE_CYC(20)) i_sto_link_chk (.mclk(mclk), .rst(rst),
		.safetyInputOne(lnk.safetyInputOne), .safetyInputTwo(lnk.safetyInputTwo),
		.forcedStopTwoInput(lnk.forcedStopTwoInput), .shutoffMonitorOne(lnk.shutoffMonitorOne),
		.shutoffMonitorTwo(lnk.shutoffMonitorTwo),
		.shutoffMonitorSeries(lnk.shutoffMonitorSeries));

	// Clock of 40 ns
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	task automatic results();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic cmp(input logic [1:0] k, input logic [35:0] got);
		sto_note_s n;
		checked++;
		if (notes.size() == 0) begin
			errors++;
			$display("ERROR %0t: result with no note", $time);
		end else begin
			n = notes.pop_front();
			if (n.kind !== k || (got & n.mask) !== (n.val & n.mask)) begin
				errors++;
				$display("ERROR %0t: kind %0d got %h exp %h", $time, k, got, n.val);
			end
		end
	endtask

	// Takes the oldest note whenever a result shows up
	always @(posedge mclk) begin
		if (rvalid && rready) cmp(2'h1, {2'h0, rresp, rdata});
		if (bvalid && bready) cmp(2'h2, 36'(bresp));
		if (snapReq) cmp(2'h0, 36'(pins));
		cycles++;
		if (cycles == 6000) begin
			errors++;
			results();
		end
	end

	task automatic axW(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge mclk);
		notes.push_back('{2'h2, 36'(r), ALL});
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
	endtask

	task automatic axR(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge mclk);
		notes.push_back('{2'h1, {2'h0, r, d}, ALL});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
	endtask

	// Samples all pins at the second edge after the call
	task automatic snap(input logic [35:0] e, input logic [35:0] m);
		@(posedge mclk);
		notes.push_back('{2'h0, e, m});
		snapReq <= 1'b1;
		@(posedge mclk);
		snapReq <= 1'b0;
	endtask

	task automatic release_all();
		axW(REG_CTRL, 32'h6, RESP_OKAY);
		axW(REG_CTRL, 32'h0, RESP_OKAY);
		repeat (12) @(posedge mclk);
	endtask

	initial begin
		rst = 1'b1;
		{servoOnCmd, motorStopped} = 2'b11;
		{motorMoving, torqueMode, alarmClear, inB1, inB2, snapReq} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		strb = 4'hf;
		rnd = $urandom(32'h8c8752e4);
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		rnd = $urandom;
		snap(16'h08f7, 16'hffff);
		axR(REG_CTRL, 32'h1, RESP_OKAY);
		axR(REG_IRQ_MASK, 32'h0, RESP_OKAY);
		axR(REG_STATUS, 32'h7, RESP_OKAY);
		axW(REG_STATUS, rnd, RESP_OKAY);
		axR(REG_STATUS, 32'h7, RESP_OKAY);
		axW(5'h14, rnd, RESP_SLVERR);
		axR(5'h14, 32'h0, RESP_SLVERR);
		axR(REG_CMD, 32'h0, RESP_OKAY);
		axR(REG_IRQ_STAT, 32'h0, RESP_OKAY);
		axW(REG_IRQ_STAT, 32'h7, RESP_OKAY);
		axR(REG_IRQ_STAT, 32'h0, RESP_OKAY);
		axW(REG_IRQ_MASK, {rnd[31:3], 3'h2}, RESP_OKAY);
		axR(REG_IRQ_MASK, 32'h2, RESP_OKAY);
		// A write without its low byte lane leaves the register alone
		strb <= {rnd[3:1], 1'b0};
		axW(REG_IRQ_MASK, 32'h5, RESP_OKAY);
		strb <= 4'hf;
		axR(REG_IRQ_MASK, 32'h2, RESP_OKAY);
		$display("test regs done");
		release_all();
		axR(REG_STATUS, 32'h8, RESP_OKAY);
		snap(16'h8017, 16'hffff);
		servoOnCmd <= 1'b0;
		repeat (3) @(posedge mclk);
		servoOnCmd <= 1'b1;
		repeat (4) @(posedge mclk);
		snap(16'hc017, 16'hffff);
		axW(REG_IRQ_STAT, 32'h2, RESP_OKAY);
		snap(16'h4017, 16'hffff);
		$display("test release done");
		axW(REG_CMD, 32'h1, RESP_OKAY);
		repeat (40) @(posedge mclk);
		snap(16'h4017, 16'hffff);
		$display("test pulse done");
		motorMoving <= 1'b1;
		motorStopped <= 1'b0;
		axW(REG_CTRL, 32'h1, RESP_OKAY);
		repeat (4) @(posedge mclk);
		snap(16'h6017, 16'hffff);
		axR(REG_STATUS, 32'h18, RESP_OKAY);
		motorMoving <= 1'b0;
		motorStopped <= 1'b1;
		repeat (40) @(posedge mclk);
		snap({20'h1, 16'h08f7}, {20'hfffff, 16'hefff});
		axR(REG_IRQ_STAT, 32'h1, RESP_OKAY);
		axW(REG_IRQ_MASK, 32'h3, RESP_OKAY);
		snap(16'h88f7, 16'hefff);
		axW(REG_IRQ_STAT, 32'h1, RESP_OKAY);
		snap(16'h08f7, 16'hefff);
		$display("test stop done");
		release_all();
		servoOnCmd <= 1'b0;
		repeat (3) @(posedge mclk);
		servoOnCmd <= 1'b1;
		torqueMode <= 1'b1;
		motorMoving <= 1'b1;
		motorStopped <= 1'b0;
		axW(REG_CTRL, 32'h1, RESP_OKAY);
		repeat (4) @(posedge mclk);
		snap(16'h9017, 16'hffff);
		motorStopped <= 1'b1;
		repeat (40) @(posedge mclk);
		snap(16'h9cf7, 16'hffff);
		motorMoving <= 1'b0;
		alarmClear <= 1'b1;
		@(posedge mclk);
		alarmClear <= 1'b0;
		torqueMode <= 1'b0;
		repeat (3) @(posedge mclk);
		snap(16'h88f7, 16'hefff);
		$display("test alarm done");
		{inB1, inB2} <= 2'b11;
		repeat (10) @(posedge mclk);
		snap(16'h0000, 16'h001f);
		foreach (cases[i]) begin
			{inB1, inB2} <= cases[i];
			repeat (30) @(posedge mclk);
			snap({11'h0, 1'b1, ^cases[i], ~cases[i], &(~cases[i])}, 16'h001f);
			{inB1, inB2} <= 2'b11;
			repeat (10) @(posedge mclk);
		end
		inB1 <= 1'b0;
		repeat (12) @(posedge mclk);
		inB1 <= 1'b1;
		repeat (10) @(posedge mclk);
		snap(16'h0000, 16'h001f);
		snap({20'h2, 16'h0000}, {20'hfffff, 16'h0000});
		$display("test channels done");
		results();
	end
endmodule
`default_nettype wire
